/* pkg/vss_consts.svh */
// Purpose: Offsets, field positions and reset values of the standard select bank
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes:   Ranges are given as bit ranges for use in part selects
`ifndef VSS_CONSTS_SVH
`define VSS_CONSTS_SVH
// ----------------------------------------
// Register indexes
// ----------------------------------------
`define VSS_IDX_STD      6'h20
`define VSS_IDX_INSEL    6'h21
`define VSS_IDX_PIC      6'h22
`define VSS_IDX_DLY      6'h23
`define VSS_IDX_IRQ_STS  6'h24
`define VSS_IDX_IRQ_MSK  6'h25
// ----------------------------------------
// Reset values
// ----------------------------------------
`define VSS_STD_RST      12'h000
`define VSS_INSEL_RST    12'h024
`define VSS_PIC_RST      12'h000
`define VSS_DLY_RST      12'h000
`define VSS_IRQ_RST      2'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define VSS_STD_CODE     2:0
`define VSS_STD_MOD      3
`define VSS_STD_COMB     5
`define VSS_STD_HBAND    6
`define VSS_STD_OPT      10:7
`define VSS_STD_DONE     11
`define VSS_STD_WMASK    12'hfef
`define VSS_INSEL_LUMA   1:0
`define VSS_INSEL_CHROMA 2
`define VSS_INSEL_IFC    4:3
`define VSS_INSEL_CBW    6:5
`define VSS_INSEL_NOTCH  7
`define VSS_INSEL_LOWP   8
`define VSS_INSEL_HPLL   10:9
`define VSS_DLY_LUMA     11:6
`define VSS_DLY_WMASK    12'hfc0
`define VSS_IRQ_DONE     0
`define VSS_IRQ_RESTART  1
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define VSS_RESP_OKAY    2'h0
`define VSS_RESP_SLVERR  2'h2
`endif

/* pkg/vss_pkg.sv */
// Purpose: Types shared by the standard select bank
// Assumes: Nothing beyond the constants header
// Notes:   Standard order follows the 3-bit standard code
package vss_pkg;
  typedef enum logic [2:0] {
    VSS_PAL_BGHI, VSS_NTSC_M, VSS_SECAM, VSS_NTSC_443,
    VSS_PAL_M, VSS_PAL_N, VSS_PAL_60, VSS_NTSC_COMB
  } vss_std_t;

  typedef enum logic [2:0] {
    VSS_S_IDLE, VSS_S_HPLL, VSS_S_VERT, VSS_S_ACC, VSS_S_COMB
  } vss_seq_st_t;
endpackage

/* hw/vss_init_seq.sv */
// Purpose: Standard initialization sequencer
// Assumes: start_i is a one-cycle pulse; a new start restarts the sequence
// Notes:   Each setup step lasts STEP_CYC cycles
`timescale 1ns/10ps
module vss_init_seq
  import vss_pkg::*;
  #(parameter int unsigned STEP_CYC = 16)
  (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       start_i,
  input  wire logic [3:0] opt_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [3:0]      step_o
  );

  vss_seq_st_t state_q, state_d;
  logic [15:0] cnt_q;
  logic [3:0]  opt_q;

  // ----------------------------------------
  // Step selection
  // ----------------------------------------
  // Comb-only option overrides every other skip bit
  function automatic vss_seq_st_t next_st(input vss_seq_st_t cur, input logic [3:0] opt);
    next_st = VSS_S_COMB;
    if (cur == VSS_S_IDLE && !opt[0] && !opt[3]) begin
      next_st = VSS_S_HPLL;
    end else if ((cur == VSS_S_IDLE || cur == VSS_S_HPLL) && !opt[1] && !opt[3]) begin
      next_st = VSS_S_VERT;
    end else if (cur != VSS_S_ACC && !opt[2] && !opt[3]) begin
      next_st = VSS_S_ACC;
    end
  endfunction

  wire step_end = (cnt_q == 16'(STEP_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      VSS_S_IDLE: state_d = state_q;
      VSS_S_COMB: if (step_end) state_d = VSS_S_IDLE;
      default:    if (step_end) state_d = next_st(state_q, opt_q);
    endcase
    if (start_i) state_d = next_st(VSS_S_IDLE, opt_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= VSS_S_IDLE;
      cnt_q   <= 16'h0000;
      opt_q   <= 4'h0;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      step_o  <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (start_i || step_end) ? 16'h0000 : cnt_q + 16'h0001;
      if (start_i) opt_q <= opt_i;
      busy_o  <= (state_d != VSS_S_IDLE);
      done_o  <= (state_q == VSS_S_COMB) && step_end && !start_i;
      step_o  <= {state_d == VSS_S_COMB, state_d == VSS_S_ACC,
                  state_d == VSS_S_VERT, state_d == VSS_S_HPLL};
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_skip_hpll;
    @(posedge clk_i) disable iff (reset_i)
      step_o[0] |-> !opt_q[0] && !opt_q[3];
  endproperty
  a_skip_hpll: assert property (p_skip_hpll) else $error("hpll step despite skip");

  property p_comb_only;
    @(posedge clk_i) disable iff (reset_i)
      (start_i && opt_i[3]) |=> step_o == 4'h8;
  endproperty
  a_comb_only: assert property (p_comb_only) else $error("comb-only did not go to comb");
endmodule

/* hw/vss_regs.sv */
// Purpose: Standard and input select register bank with AXI4-Lite access
// Assumes: One write and one read under way at a time
// Notes:   Picture start and luma delay apply on the next standard write
`timescale 1ns/10ps
`include "vss_consts.svh"
module vss_regs
  import vss_pkg::*;
  #(parameter int unsigned STEP_CYC = 16)
  (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [2:0]       std_code_o,
  output logic             simple_pal_o,
  output logic             comp_ntsc_o,
  output logic             mono_o,
  output logic             mono_625_o,
  output logic             comb_en_o,
  output logic             hband_en_o,
  output logic [2:0]       luma_input_o,
  output logic             chroma_from_cin_o,
  output logic [1:0]       if_comp_o,
  output logic [1:0]       chroma_bw_o,
  output logic             notch_fixed_o,
  output logic             luma_lowpass_o,
  output logic [1:0]       hpll_speed_o,
  output logic [11:0]      pic_start_o,
  output logic [5:0]       luma_delay_o,
  output logic             init_busy_o,
  output logic [3:0]       init_step_o,
  output logic             irq_o
  );

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [11:0] merge(input logic [11:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = {strb[1] ? d[11:8] : old[11:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // Returns {mono_625, mono, comp_ntsc, simple_pal}
  function automatic logic [3:0] mod_flags(input logic [11:0] std);
    vss_std_t code;
    logic     m;
    code = vss_std_t'(std[`VSS_STD_CODE]);
    m    = std[`VSS_STD_MOD];
    mod_flags = 4'h0;
    case (code)
      VSS_PAL_BGHI, VSS_PAL_M, VSS_PAL_N, VSS_PAL_60: mod_flags[0] = m;
      VSS_NTSC_M, VSS_NTSC_443:                       mod_flags[1] = m;
      VSS_SECAM:                                      mod_flags[3:2] = {m, m};
      VSS_NTSC_COMB:                                  mod_flags[2] = m;
      default:                                        mod_flags = 4'h0;
    endcase
  endfunction

  function automatic logic [2:0] luma_map(input logic [1:0] sel);
    case (sel)
      2'h0:    luma_map = 3'h3;
      2'h1:    luma_map = 3'h2;
      2'h2:    luma_map = 3'h1;
      default: luma_map = 3'h4;
    endcase
  endfunction

  // ----------------------------------------
  // Bus write path
  // ----------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0]  wr_strb_q;
  logic [11:0] std_q, insel_q, pic_q, dly_q;
  logic [11:0] std_d;
  logic [1:0]  sts_q, msk_q, sts_d;
  logic        start_q;
  logic        seq_busy, seq_done;

  wire aw_hs     = s_axi_awvalid_i & s_axi_awready_o;
  wire w_hs      = s_axi_wvalid_i & s_axi_wready_o;
  wire do_wr     = aw_have_q & w_have_q & ~s_axi_bvalid_o;
  wire [5:0] wix = wr_addr_q[7:2];
  wire wr_std    = do_wr & (wix == `VSS_IDX_STD);
  wire wr_insel  = do_wr & (wix == `VSS_IDX_INSEL);
  wire wr_pic    = do_wr & (wix == `VSS_IDX_PIC);
  wire wr_dly    = do_wr & (wix == `VSS_IDX_DLY);
  wire wr_sts    = do_wr & (wix == `VSS_IDX_IRQ_STS);
  wire wr_msk    = do_wr & (wix == `VSS_IDX_IRQ_MSK);
  wire wr_hit    = wr_std | wr_insel | wr_pic | wr_dly | wr_sts | wr_msk;
  wire aw_have_d = (aw_have_q | aw_hs) & ~do_wr;
  wire w_have_d  = (w_have_q | w_hs) & ~do_wr;
  wire bvalid_d  = do_wr | (s_axi_bvalid_o & ~s_axi_bready_i);
  wire [11:0] wr_merged = merge(wr_wr_old(wix), wr_data_q, wr_strb_q);

  function automatic logic [11:0] wr_wr_old(input logic [5:0] ix);
    case (ix)
      `VSS_IDX_STD:   wr_wr_old = std_q;
      `VSS_IDX_INSEL: wr_wr_old = insel_q;
      `VSS_IDX_PIC:   wr_wr_old = pic_q;
      `VSS_IDX_DLY:   wr_wr_old = dly_q;
      default:        wr_wr_old = 12'h000;
    endcase
  endfunction

  // Done set wins over a software write of zero
  always_comb begin
    std_d = std_q;
    if (wr_std) std_d = wr_merged & `VSS_STD_WMASK;
    if (seq_done) std_d[`VSS_STD_DONE] = 1'b1;
  end

  // Restart flags a new init request while one is running
  wire restart_ev = start_q & seq_busy;
  wire [1:0] sts_clr = (wr_sts & wr_strb_q[0]) ? wr_data_q[1:0] : 2'h0;
  assign sts_d = (sts_q & ~sts_clr) | {restart_ev, seq_done};
  wire [3:0] flags_d = mod_flags(std_d);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      wr_addr_q       <= 8'h00;
      wr_data_q       <= 32'h0000_0000;
      wr_strb_q       <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `VSS_RESP_OKAY;
    end else begin
      aw_have_q       <= aw_have_d;
      w_have_q        <= w_have_d;
      if (aw_hs) wr_addr_q <= s_axi_awaddr_i;
      if (w_hs) wr_data_q <= s_axi_wdata_i;
      if (w_hs) wr_strb_q <= s_axi_wstrb_i;
      s_axi_awready_o <= ~aw_have_d & ~bvalid_d;
      s_axi_wready_o  <= ~w_have_d & ~bvalid_d;
      s_axi_bvalid_o  <= bvalid_d;
      if (do_wr) s_axi_bresp_o <= wr_hit ? `VSS_RESP_OKAY : `VSS_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      std_q        <= `VSS_STD_RST;
      insel_q      <= `VSS_INSEL_RST;
      pic_q        <= `VSS_PIC_RST;
      dly_q        <= `VSS_DLY_RST;
      sts_q        <= `VSS_IRQ_RST;
      msk_q        <= `VSS_IRQ_RST;
      pic_start_o  <= `VSS_PIC_RST;
      luma_delay_o <= 6'h00;
      start_q      <= 1'b0;
      irq_o        <= 1'b0;
      simple_pal_o <= 1'b0;
      comp_ntsc_o  <= 1'b0;
      mono_o       <= 1'b0;
      mono_625_o   <= 1'b0;
      luma_input_o <= 3'h3;
    end else begin
      std_q   <= std_d;
      if (wr_insel) insel_q <= wr_merged;
      if (wr_pic) pic_q <= wr_merged;
      if (wr_dly) dly_q <= wr_merged & `VSS_DLY_WMASK;
      if (wr_msk) msk_q <= wr_strb_q[0] ? wr_data_q[1:0] : msk_q;
      sts_q   <= sts_d;
      // Shadowed values reach the datapath only with a standard update
      if (wr_std) pic_start_o <= pic_q;
      if (wr_std) luma_delay_o <= dly_q[`VSS_DLY_LUMA];
      start_q <= wr_std | wr_insel;
      irq_o   <= |(sts_q & msk_q);
      {mono_625_o, mono_o, comp_ntsc_o, simple_pal_o} <= flags_d;
      luma_input_o <= luma_map(insel_q[`VSS_INSEL_LUMA]);
    end
  end

  assign std_code_o        = std_q[`VSS_STD_CODE];
  assign comb_en_o         = std_q[`VSS_STD_COMB];
  assign hband_en_o        = std_q[`VSS_STD_HBAND];
  assign chroma_from_cin_o = insel_q[`VSS_INSEL_CHROMA];
  assign if_comp_o         = insel_q[`VSS_INSEL_IFC];
  assign chroma_bw_o       = insel_q[`VSS_INSEL_CBW];
  assign notch_fixed_o     = insel_q[`VSS_INSEL_NOTCH];
  assign luma_lowpass_o    = insel_q[`VSS_INSEL_LOWP];
  assign hpll_speed_o      = insel_q[`VSS_INSEL_HPLL];
  assign init_busy_o       = seq_busy;

  // ----------------------------------------
  // Initialization sequencer
  // ----------------------------------------
  vss_init_seq #(.STEP_CYC(STEP_CYC)) u_seq (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (start_q),
    .opt_i   (std_q[`VSS_STD_OPT]),
    .busy_o  (seq_busy),
    .done_o  (seq_done),
    .step_o  (init_step_o)
  );

  // ----------------------------------------
  // Bus read path
  // ----------------------------------------
  wire ar_hs     = s_axi_arvalid_i & s_axi_arready_o;
  wire [5:0] rix = s_axi_araddr_i[7:2];
  wire rd_hit    = (rix >= `VSS_IDX_STD) && (rix <= `VSS_IDX_IRQ_MSK);
  wire [11:0] rd_val = (rix == `VSS_IDX_IRQ_STS) ? {10'h000, sts_q} :
                       (rix == `VSS_IDX_IRQ_MSK) ? {10'h000, msk_q} : wr_wr_old(rix);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `VSS_RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~(ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i));
      s_axi_rvalid_o  <= ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i);
      if (ar_hs) s_axi_rdata_o <= {20'h00000, rd_val};
      if (ar_hs) s_axi_rresp_o <= rd_hit ? `VSS_RESP_OKAY : `VSS_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_reset_dflt;
    disable iff (1'b0) reset_i |=> std_q == `VSS_STD_RST && insel_q == `VSS_INSEL_RST;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset default wrong");

  property p_std_code;
    (wr_std && wr_strb_q[0]) |=> std_code_o == $past(wr_data_q[2:0]);
  endproperty
  a_std_code: assert property (p_std_code) else $error("standard code not taken");

  property p_mono;
    mono_o |-> std_q[`VSS_STD_MOD] &&
               (std_code_o == VSS_SECAM || std_code_o == VSS_NTSC_COMB);
  endproperty
  a_mono: assert property (p_mono) else $error("mono without cause");

  property p_resv_zero;
    std_q[4] == 1'b0 && dly_q[5:0] == 6'h00;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits stored");

  property p_done_set;
    seq_done |=> std_q[`VSS_STD_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done bit not set");

  sequence s_insel_wr;
    wr_insel;
  endsequence
  sequence s_init_run;
    start_q ##1 init_busy_o;
  endsequence
  property p_insel_init;
    s_insel_wr |=> s_init_run;
  endproperty
  a_insel_init: assert property (p_insel_init) else $error("insel write no init");

  property p_pic_hold;
    !$past(wr_std) |-> $stable(pic_start_o);
  endproperty
  a_pic_hold: assert property (p_pic_hold) else $error("picture start changed early");

  property p_irq;
    ##1 irq_o == |($past(sts_q) & $past(msk_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

/* testbench/test_vss_regs.sv */
// Purpose: Self-checking bench for the standard select register bank
// Assumes: Registered AXI4-Lite answers; STEP_CYC shortened to 2
// Notes:   Outputs are sampled right after a rising edge, before that edge's updates land
`timescale 1ns/10ps
`include "vss_consts.svh"
module test_vss_regs;
  import vss_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  std_code, luma_in;
  logic        spal, cntsc, mono, mono625, comb, hband, chroma_input, notch, lowp, busy, irq;
  logic [1:0]  ifc, cbw, hpll;
  logic [11:0] pic;
  logic [5:0]  ldly;
  logic [3:0]  step, seen;
  int          fails = 0;
  int          num_checks = 0;
  logic [1:0]  r;
  logic [31:0] d;

  always #20 clk_i = ~clk_i;

  vss_regs #(.STEP_CYC(2)) uut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .std_code_o(std_code), .simple_pal_o(spal), .comp_ntsc_o(cntsc), .mono_o(mono),
    .mono_625_o(mono625), .comb_en_o(comb), .hband_en_o(hband), .luma_input_o(luma_in),
    .chroma_from_cin_o(chroma_input), .if_comp_o(ifc), .chroma_bw_o(cbw), .notch_fixed_o(notch),
    .luma_lowpass_o(lowp), .hpll_speed_o(hpll), .pic_start_o(pic), .luma_delay_o(ldly),
    .init_busy_o(busy), .init_step_o(step), .irq_o(irq)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Offers AW and W together, releases each when taken, holds bready until bvalid
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit aw, w, b;
    int n;
    aw = 0; w = 0; b = 0; n = 0;
    @(posedge clk_i);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b && n < 100) begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready) begin aw = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w = 1; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin b = 1; resp = bresp; bready <= 1'b0; end
    end
    if (!b) begin fails++; $display("[ERR] t=%0t got %h exp %h", $time, 0, 1); end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    bit got;
    int n;
    got = 0; n = 0;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!got && n < 100) begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin got = 1; v = rdata; resp = rresp; rready <= 1'b0; end
    end
    if (!got) begin fails++; $display("[ERR] t=%0t got %h exp %h", $time, 0, 1); end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    axr(a, v, rs);
    chk(v, exp);
    chk(rs, `VSS_RESP_OKAY);
  endtask

  // Bounded wait for busy to rise, then to fall; collects the steps seen
  task automatic wait_init;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
    chk(busy, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      seen = seen | step;
      @(posedge clk_i);
      n++;
    end
    chk(busy, 1'b0);
    repeat (2) @(posedge clk_i);
  endtask

  function automatic logic [3:0] mod_exp(input logic [2:0] c, input logic m);
    // Order {simple_pal, comp_ntsc, mono, mono_625}
    return {m & (c == 0 || c == 4 || c == 5 || c == 6), m & (c == 1 || c == 3),
            m & (c == 2 || c == 7), m & (c == 2)};
  endfunction

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin : tests
    logic [2:0] lut [4];
    logic [3:0] opt_exp [5];
    logic [11:0] opts [5];
    lut = '{3'h3, 3'h2, 3'h1, 3'h4};
    opts = '{12'h000, 12'h080, 12'h100, 12'h200, 12'h400};
    opt_exp = '{4'hf, 4'he, 4'hd, 4'hb, 4'h8};
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdchk(8'h80, 32'h000);
    rdchk(8'h84, 32'h024);
    rdchk(8'h88, 32'h000);
    rdchk(8'h8c, 32'h000);
    chk({luma_in, chroma_input, cbw, pic, ldly}, {3'h3, 1'b1, 2'h1, 12'h0, 6'h0});
    // Unmapped place refuses both ways
    axw(8'h98, 32'h1, r);
    chk(r, `VSS_RESP_SLVERR);
    axr(8'h98, d, r);
    chk(r, `VSS_RESP_SLVERR);
    chk(d, 32'h0);
    // Input select fields and source mapping
    for (int i = 0; i < 4; i++) begin
      d = (i << 9) | (i[0] << 8) | (i[1] << 7) | (i << 5) | (i << 3) | (i[0] << 2) | i;
      axw(8'h84, d, r);
      wait_init();
      chk({luma_in, chroma_input, ifc, cbw, notch, lowp, hpll},
          {lut[i], i[0], i[1:0], i[1:0], i[1], i[0], i[1:0]});
      rdchk(8'h84, d);
    end
    // Picture start and luma delay wait for a standard write
    axw(8'h88, 32'h123, r);
    axw(8'h8c, 32'hfff, r);
    repeat (2) @(posedge clk_i);
    chk({pic, ldly}, {12'h000, 6'h00});
    rdchk(8'h8c, 32'hfc0);
    axw(8'h84, 32'h024, r);
    wait_init();
    chk({pic, ldly}, {12'h000, 6'h00});
    // Every code with and without modifier; reserved bit written as one
    for (int c = 0; c < 16; c++) begin
      d = 32'h470 | c;
      axw(8'h80, d, r);
      wait_init();
      chk({std_code, spal, cntsc, mono, mono625}, {c[2:0], mod_exp(c[2:0], c[3])});
      chk({comb, hband}, 2'b11);
      rdchk(8'h80, (d & 32'hfef) | 32'h800);
    end
    chk({pic, ldly}, {12'h123, 6'h3f});
    // Option bits skip steps
    for (int k = 0; k < 5; k++) begin
      seen = 4'h0;
      axw(8'h80, opts[k], r);
      wait_init();
      chk(seen, opt_exp[k]);
      chk({comb, hband}, 2'b00);
      rdchk(8'h80, opts[k] | 32'h800);
    end
    // Restart, status, mask and clear
    axw(8'h90, 32'h3, r);
    axw(8'h80, 32'h000, r);
    axw(8'h84, 32'h024, r);
    wait_init();
    rdchk(8'h90, 32'h3);
    chk(irq, 1'b0);
    axw(8'h94, 32'h2, r);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    axw(8'h90, 32'h1, r);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    axw(8'h90, 32'h2, r);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rdchk(8'h90, 32'h0);
    rdchk(8'h94, 32'h2);
    // Mid-run reset must drop the written standard, picture start, delay and mask values
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdchk(8'h80, 32'h000);
    rdchk(8'h88, 32'h000);
    rdchk(8'h8c, 32'h000);
    rdchk(8'h94, 32'h000);
    chk({pic, ldly, irq}, 19'h0);
    close_out();
  end
endmodule
